// [rtl/fault_status_consts.vh]
// Constants for the controller fault and status unit.
// What this block does
// - Watchdog overrun halts as blocking software fault.
// - Chart overrun or unresolved step sets chart flag.
// - Halt instruction loads code, sets no flag.
// - Unresolved jump loads code, sets no flag.
// - Blocking string error sets flag and code.
// - Blocking arithmetic faults set flag and codes.
// - Blocking faults record code; index sets flag.
// - Serious fault stops in error, forces stop.
// - System fault word gets 0x80 or 0x81.
// - Error state blocks diagnostics until cold start.
// - Cold-start flag set by causes, cleared after scan.
// - Restart word bit 0 low after cold restart.
// - Four time bases toggle 5ms/50ms/500ms/30s free-running.
// - Fallback control forces outputs to fallback level.
// - I/O flag high, low during rack fault.
// - Blocking fault halts application immediately.
`ifndef FAULT_STATUS_CONSTS_VH
`define FAULT_STATUS_CONSTS_VH

`define CLK_HZ            50000000
`define TB0_HALF_US       5000
`define TB1_HALF_US       50000
`define TB2_HALF_US       500000
`define TB3_HALF_US       30000000

`define CODE_WATCHDOG     16'hdeb0
`define CODE_CHART_TABLE  16'hdef7
`define CODE_CHART_STEP   16'hdefe
`define CODE_HALT_INSTR   16'h2258
`define CODE_JUMP         16'hdef8
`define CODE_STRING       16'hdef1
`define CODE_DIV_ZERO     16'hdef0
`define CODE_OVERFLOW     16'hdef2
`define CODE_FLOAT        16'hde87
`define CODE_INDEX        16'hdef3
`define SYS_CODE_WDOG     8'h80
`define SYS_CODE_WIRING   8'h81

`define ADDR_CTRL         12'h000
`define ADDR_STATUS       12'h004
`define ADDR_FAULT_TYPE   12'h008
`define ADDR_SYS_FAULT    12'h00c
`define ADDR_RESTART      12'h010
`define ADDR_IRQ_STATUS   12'h014
`define ADDR_IRQ_MASK     12'h018
`define ADDR_EXEC_LIMIT   12'h01c
`define ADDR_CAUSE_CMD    12'h020

`define CTRL_FALLBACK     0
`define CTRL_COLD_REQ     1
`define CTRL_WARM_REQ     2
`define CTRL_RUN_REQ      3
`define CTRL_INIT_REQ     4

`define ST_EXEC_WDOG      0
`define ST_CHART          1
`define ST_STRING         2
`define ST_ARITH          3
`define ST_INDEX          4
`define ST_COLD           5
`define ST_WARM           6
`define ST_IO_OK          7
`define ST_TB0            8
`define ST_TB1            9
`define ST_TB2            10
`define ST_TB3            11
`define ST_STATE_LSB      12

`define IRQ_BLOCKING      0
`define IRQ_SYSTEM        1
`define IRQ_IO            2
`define IRQ_WDOG          3

`define EXEC_LIMIT_RST    32'h000f4240

`endif

// [rtl/time_base_toggle.v]
// Free-running toggle bit with a fixed half period.
`timescale 1ns/1ns
module time_base_toggle #(
  parameter HALF_CYCLES = 250000
) (
  input  wire clk_sys_i,
  input  wire rst_n_i,
  output reg  tick_o
);
  reg [31:0] count;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (count == HALF_CYCLES - 1) begin
      count  <= 32'h00000000;
      tick_o <= ~tick_o;
    end else begin
      count <= count + 32'h00000001;
    end
  end
endmodule // time_base_toggle

// [rtl/controller_fault_status_unit.v]
// Fault recording, run state and system status bits behind an APB slave.
`timescale 1ns/1ns
`include "fault_status_consts.vh"
module controller_fault_status_unit #(
  parameter TB3_CYCLES = `TB3_HALF_US / 1000 * (`CLK_HZ / 1000),
  parameter TB2_CYCLES = `TB2_HALF_US / 1000 * (`CLK_HZ / 1000),
  parameter TB1_CYCLES = `TB1_HALF_US / 1000 * (`CLK_HZ / 1000),
  parameter TB0_CYCLES = `TB0_HALF_US / 1000 * (`CLK_HZ / 1000)
) (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output reg         pslverr_o,
  input  wire        scan_end_i,
  input  wire        outputs_update_i,
  input  wire        power_loss_data_i,
  input  wire        power_save_data_i,
  input  wire        card_change_i,
  input  wire        reset_button_i,
  input  wire        chart_table_ovf_i,
  input  wire        chart_step_unres_i,
  input  wire        halt_instr_i,
  input  wire        jump_unres_i,
  input  wire        string_err_i,
  input  wire        div_zero_i,
  input  wire        cap_ovf_i,
  input  wire        float_err_i,
  input  wire        index_ovf_i,
  input  wire        diag_blocking_i,
  input  wire        sys_watchdog_i,
  input  wire        wiring_fault_i,
  input  wire        rack_io_fault_i,
  output wire        app_run_o,
  output wire        app_halt_o,
  output wire        app_error_o,
  output wire        outputs_fallback_o,
  output wire        diag_comm_en_o,
  output wire        irq_o
);
  localparam [3:0] S_STOP  = 4'b0001;
  localparam [3:0] S_RUN   = 4'b0010;
  localparam [3:0] S_HALT  = 4'b0100;
  localparam [3:0] S_ERROR = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  localparam NSYNC = 19;
  wire [NSYNC-1:0] raw_in = {scan_end_i, outputs_update_i, power_loss_data_i, power_save_data_i,
                             card_change_i, reset_button_i, chart_table_ovf_i, chart_step_unres_i,
                             halt_instr_i, jump_unres_i, string_err_i, div_zero_i, cap_ovf_i,
                             float_err_i, index_ovf_i, diag_blocking_i, sys_watchdog_i,
                             wiring_fault_i, rack_io_fault_i};
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;
  reg  [NSYNC-1:0] sync_c;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= {NSYNC{1'b0}};
      sync_b <= {NSYNC{1'b0}};
      sync_c <= {NSYNC{1'b0}};
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end
  // Event pins act once, on the rising edge seen past the second stage; the diagnostics
  // and rack pins are levels and are read from the second stage directly.
  wire [NSYNC-1:0] rise = sync_b & ~sync_c;
  wire scan_end     = rise[18];
  wire outputs_upd  = rise[17];
  wire pwr_loss     = rise[16];
  wire pwr_save     = rise[15];
  wire card_chg     = rise[14];
  wire rst_button   = rise[13];
  wire chart_tab    = rise[12];
  wire chart_step   = rise[11];
  wire halt_instr   = rise[10];
  wire jump_unres   = rise[9];
  wire string_err   = rise[8];
  wire div_zero     = rise[7];
  wire cap_ovf      = rise[6];
  wire float_err    = rise[5];
  wire index_ovf    = rise[4];
  wire diag_block   = sync_b[3];
  wire sys_wdog     = rise[2];
  wire wiring_flt   = rise[1];
  wire rack_io_flt  = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [15:0] fault_type_word;
  reg  [7:0]  system_fault_word;
  reg  [7:0]  sys_fault_latched;
  reg         exec_watchdog_flag;
  reg         chart_fault_flag;
  reg         string_fault_flag;
  reg         arith_fault_flag;
  reg         index_fault_flag;
  reg         cold_start_flag;
  reg         warm_restart_flag;
  reg         warm_first_scan;
  reg         restart_bit0;
  reg         force_stop;
  reg         global_fallback_ctrl;
  reg  [31:0] exec_limit;
  reg  [31:0] exec_count;
  reg  [3:0]  irq_status;
  reg  [3:0]  irq_mask;
  wire        tick_10ms_bit;
  wire        tick_100ms_bit;
  wire        tick_1s_bit;
  wire        tick_1min_bit;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; the slave answers in the access cycle with no wait states.
  assign pready_o = 1'b1;
  wire wr = psel_i & penable_i & pwrite_i;
  wire wr_ctrl  = wr && (paddr_i == `ADDR_CTRL);
  wire wr_stat  = wr && (paddr_i == `ADDR_STATUS);
  wire wr_ftype = wr && (paddr_i == `ADDR_FAULT_TYPE);
  wire wr_irqs  = wr && (paddr_i == `ADDR_IRQ_STATUS);
  wire wr_mask  = wr && (paddr_i == `ADDR_IRQ_MASK);
  wire wr_limit = wr && (paddr_i == `ADDR_EXEC_LIMIT);
  wire wr_cmd   = wr && (paddr_i == `ADDR_CAUSE_CMD);
  wire sw_cold  = wr_cmd & pwdata_i[`CTRL_COLD_REQ];
  wire sw_warm  = wr_cmd & pwdata_i[`CTRL_WARM_REQ];
  wire sw_run   = wr_cmd & pwdata_i[`CTRL_RUN_REQ];
  wire sw_init  = wr_cmd & pwdata_i[`CTRL_INIT_REQ];

  wire exec_ovf = (state == S_RUN) && (exec_count >= exec_limit);
  wire blk_diag = diag_block & (string_err | div_zero | cap_ovf | float_err | index_ovf);
  wire blocking = exec_ovf | chart_tab | chart_step | halt_instr | jump_unres | blk_diag;
  wire sys_flt  = sys_wdog | wiring_flt;
  wire cold_evt = pwr_loss | sw_cold | card_chg | rst_button;

  ////////////////////////////////////////////////////////////////////////////
  // Run state machine.
  always @* begin
    next_state = state;
    case (state)
      S_STOP: begin
        if (sw_run) next_state = S_RUN;
      end
      S_RUN: begin
        if (blocking) next_state = S_HALT;
      end
      S_HALT: begin
        if (sw_init | rst_button) next_state = S_STOP;
      end
      S_ERROR: begin
        next_state = S_ERROR;
      end
      default: next_state = S_STOP;
    endcase
    if (sys_flt) next_state = S_ERROR;
    else if (cold_evt) next_state = force_stop ? S_STOP : next_state;
    if (cold_evt && state == S_ERROR) next_state = S_STOP;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= S_STOP;
      exec_count <= 32'h00000000;
    end else begin
      state <= next_state;
      // The counter stops at the limit so the overrun stands until the state leaves RUN.
      if (state != S_RUN || scan_end) exec_count <= 32'h00000000;
      else if (!exec_ovf) exec_count <= exec_count + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags and fault words.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_type_word    <= 16'h0000;
      system_fault_word  <= 8'h00;
      sys_fault_latched  <= 8'h00;
      force_stop         <= 1'b0;
      exec_watchdog_flag <= 1'b0;
      chart_fault_flag   <= 1'b0;
      string_fault_flag  <= 1'b0;
      arith_fault_flag   <= 1'b0;
      index_fault_flag   <= 1'b0;
    end else begin
      if (wr_stat) begin
        exec_watchdog_flag <= pwdata_i[`ST_EXEC_WDOG];
        chart_fault_flag   <= pwdata_i[`ST_CHART];
        string_fault_flag  <= pwdata_i[`ST_STRING];
        arith_fault_flag   <= pwdata_i[`ST_ARITH];
        index_fault_flag   <= pwdata_i[`ST_INDEX];
      end
      if (wr_ftype) fault_type_word <= pwdata_i[15:0];
      if (state == S_RUN) begin
        if (string_err) string_fault_flag <= 1'b1;
        if (div_zero | cap_ovf | float_err) arith_fault_flag <= 1'b1;
        if (index_ovf) index_fault_flag <= 1'b1;
        if (exec_ovf) begin
          exec_watchdog_flag <= 1'b1;
          fault_type_word    <= `CODE_WATCHDOG;
        end else if (chart_tab) begin
          chart_fault_flag <= 1'b1;
          fault_type_word  <= `CODE_CHART_TABLE;
        end else if (chart_step) begin
          chart_fault_flag <= 1'b1;
          fault_type_word  <= `CODE_CHART_STEP;
        end else if (halt_instr) begin
          fault_type_word <= `CODE_HALT_INSTR;
        end else if (jump_unres) begin
          fault_type_word <= `CODE_JUMP;
        end else if (diag_block) begin
          if (string_err) fault_type_word <= `CODE_STRING;
          else if (div_zero) fault_type_word <= `CODE_DIV_ZERO;
          else if (cap_ovf) fault_type_word <= `CODE_OVERFLOW;
          else if (float_err) fault_type_word <= `CODE_FLOAT;
          else if (index_ovf) fault_type_word <= `CODE_INDEX;
        end
      end
      if (state != S_ERROR) begin
        if (wiring_flt) sys_fault_latched <= `SYS_CODE_WIRING;
        else if (sys_wdog) sys_fault_latched <= `SYS_CODE_WDOG;
        if (sys_flt) force_stop <= 1'b1;
      end
      if (cold_evt) begin
        system_fault_word <= sys_fault_latched;
        fault_type_word   <= 16'h0000;
        if (state != S_ERROR) force_stop <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart indicators and fallback control.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cold_start_flag      <= 1'b1;
      warm_restart_flag    <= 1'b0;
      warm_first_scan      <= 1'b0;
      restart_bit0         <= 1'b0;
      global_fallback_ctrl <= 1'b0;
    end else begin
      if (wr_ctrl) global_fallback_ctrl <= pwdata_i[`CTRL_FALLBACK];
      if (cold_evt) begin
        cold_start_flag <= 1'b1;
        restart_bit0    <= 1'b0;
      end else if (scan_end && state == S_RUN && !blocking) begin
        cold_start_flag <= 1'b0;
        restart_bit0    <= 1'b1;
      end
      if (pwr_save | sw_warm) begin
        warm_restart_flag <= 1'b1;
        warm_first_scan   <= 1'b0;
      end else if (warm_restart_flag && scan_end) begin
        warm_first_scan <= 1'b1;
      end else if (warm_first_scan && outputs_upd) begin
        warm_restart_flag <= 1'b0;
        warm_first_scan   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time bases.
  // The half periods are parameters so that a bench can shorten them.
  wire [3:0] tick_bits;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tbase
      time_base_toggle #(
        .HALF_CYCLES((g == 0) ? TB0_CYCLES : (g == 1) ? TB1_CYCLES : (g == 2) ? TB2_CYCLES : TB3_CYCLES)
      ) u_tbase (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .tick_o    (tick_bits[g])
      );
    end
  endgenerate
  assign tick_10ms_bit  = tick_bits[0];
  assign tick_100ms_bit = tick_bits[1];
  assign tick_1s_bit    = tick_bits[2];
  assign tick_1min_bit  = tick_bits[3];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and execution limit.
  wire io_fault_flag = ~rack_io_flt;
  wire [3:0] irq_evt = {exec_ovf, rack_io_flt & ~sync_c[0], sys_flt, blocking};
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status <= 4'h0;
      irq_mask   <= 4'h0;
      exec_limit <= `EXEC_LIMIT_RST;
    end else begin
      irq_status <= (irq_status & ~(wr_irqs ? pwdata_i[3:0] : 4'h0)) | irq_evt;
      if (wr_mask) irq_mask <= pwdata_i[3:0];
      if (wr_limit) exec_limit <= pwdata_i;
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read data; the system fault word reads zero while stopped in error.
  wire [31:0] status_word = {16'h0000, state, tick_1min_bit, tick_1s_bit, tick_100ms_bit,
                             tick_10ms_bit, io_fault_flag, warm_restart_flag, cold_start_flag,
                             index_fault_flag, arith_fault_flag, string_fault_flag,
                             chart_fault_flag, exec_watchdog_flag};
  // Read data is loaded in the setup cycle so that it stands through the access cycle.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
      if (psel_i && !penable_i) begin
        if (paddr_i == `ADDR_CTRL) prdata_o <= {31'h00000000, global_fallback_ctrl};
        else if (paddr_i == `ADDR_STATUS) prdata_o <= status_word;
        else if (paddr_i == `ADDR_FAULT_TYPE) prdata_o <= {16'h0000, fault_type_word};
        else if (paddr_i == `ADDR_SYS_FAULT)
          prdata_o <= (state == S_ERROR) ? 32'h00000000 : {24'h000000, system_fault_word};
        else if (paddr_i == `ADDR_RESTART) prdata_o <= {31'h00000000, restart_bit0};
        else if (paddr_i == `ADDR_IRQ_STATUS) prdata_o <= {28'h0000000, irq_status};
        else if (paddr_i == `ADDR_IRQ_MASK) prdata_o <= {28'h0000000, irq_mask};
        else if (paddr_i == `ADDR_EXEC_LIMIT) prdata_o <= exec_limit;
        else if (paddr_i == `ADDR_CAUSE_CMD) prdata_o <= 32'h00000000;
        else pslverr_o <= 1'b1;
      end
    end
  end

  assign app_run_o          = (state == S_RUN);
  assign app_halt_o         = (state == S_HALT);
  assign app_error_o        = (state == S_ERROR);
  assign diag_comm_en_o     = (state != S_ERROR);
  assign outputs_fallback_o = global_fallback_ctrl | (state != S_RUN);
endmodule // controller_fault_status_unit

// [bench/fault_status_chk.sv]
// Port checker for the controller fault and status unit.
`timescale 1ns/1ns
`include "fault_status_consts.vh"
module fault_status_chk (
  input wire        clk_sys_i,
  input wire        rst_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        halt_instr_i,
  input wire        wiring_fault_i,
  input wire        app_run_o,
  input wire        app_halt_o,
  input wire        app_error_o,
  input wire        outputs_fallback_o,
  input wire        diag_comm_en_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_ready; pready_o == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("pready not high");
  property p_err_acc; pslverr_o |-> psel_i && penable_i; endproperty
  a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");
  property p_rd_idle; !(psel_i && penable_i) |-> prdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero when idle");
  property p_state; $onehot0({app_run_o, app_halt_o, app_error_o}); endproperty
  a_state: assert property (p_state) else $error("more than one state");
  property p_fb; !app_run_o |-> outputs_fallback_o; endproperty
  a_fb: assert property (p_fb) else $error("outputs not in fallback");
  property p_fb_ctrl;
    psel_i && penable_i && pwrite_i && paddr_i == `ADDR_CTRL && pwdata_i[`CTRL_FALLBACK] |=> outputs_fallback_o;
  endproperty
  a_fb_ctrl: assert property (p_fb_ctrl) else $error("fallback bit not applied");
  property p_diag; diag_comm_en_o == !app_error_o; endproperty
  a_diag: assert property (p_diag) else $error("diagnostic link wrong");
  property p_halt; $rose(halt_instr_i) && app_run_o |-> ##[1:6] app_halt_o; endproperty
  a_halt: assert property (p_halt) else $error("halt late");
  property p_err; $rose(wiring_fault_i) |-> ##[1:6] app_error_o; endproperty
  a_err: assert property (p_err) else $error("error state late");
  property p_cold_stop; $fell(app_error_o) |-> !app_run_o && !app_halt_o; endproperty
  a_cold_stop: assert property (p_cold_stop) else $error("error left not to stop");
endmodule // fault_status_chk

bind controller_fault_status_unit fault_status_chk u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .halt_instr_i(halt_instr_i),
  .wiring_fault_i(wiring_fault_i), .app_run_o(app_run_o), .app_halt_o(app_halt_o),
  .app_error_o(app_error_o), .outputs_fallback_o(outputs_fallback_o), .diag_comm_en_o(diag_comm_en_o)
);

// [bench/controller_fault_status_unit_test.sv]
// Self-checking testbench for the controller fault and status unit.
`timescale 1ns/1ns
`include "fault_status_consts.vh"
module controller_fault_status_unit_test;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [16:0] ev = 17'h0;
  logic        diag = 1'b0;
  logic        rack = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          compares = 0;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, app_run_o, app_halt_o, app_error_o, fb_o, diag_o, irq_o;

  controller_fault_status_unit #(.TB3_CYCLES(13), .TB2_CYCLES(11), .TB1_CYCLES(7), .TB0_CYCLES(5)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .scan_end_i(ev[0]), .outputs_update_i(ev[1]), .power_loss_data_i(ev[2]), .power_save_data_i(ev[3]),
    .card_change_i(ev[4]), .reset_button_i(ev[5]), .chart_table_ovf_i(ev[6]), .chart_step_unres_i(ev[7]),
    .halt_instr_i(ev[8]), .jump_unres_i(ev[9]), .string_err_i(ev[10]), .div_zero_i(ev[11]),
    .cap_ovf_i(ev[12]), .float_err_i(ev[13]), .index_ovf_i(ev[14]), .diag_blocking_i(diag),
    .sys_watchdog_i(ev[15]), .wiring_fault_i(ev[16]), .rack_io_fault_i(rack), .app_run_o(app_run_o),
    .app_halt_o(app_halt_o), .app_error_o(app_error_o), .outputs_fallback_o(fb_o),
    .diag_comm_en_o(diag_o), .irq_o(irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer: setup, access until pready, then release.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdm(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    ev[i] <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdm("status", `ADDR_STATUS, 32'hf0a0, 32'h10a0);
    rdm("restart", `ADDR_RESTART, 32'h1, 32'h0);
    rdm("fault word", `ADDR_FAULT_TYPE, 32'hffffffff, 32'h0);
    wr(`ADDR_FAULT_TYPE, 32'h1234);
    rdm("fault write", `ADDR_FAULT_TYPE, 32'hffffffff, 32'h1234);
    rdm("limit", `ADDR_EXEC_LIMIT, 32'hffffffff, `EXEC_LIMIT_RST);
    xfer(1'b0, 12'h0fc, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_codes();
    int          idx [9] = '{6, 7, 8, 9, 10, 11, 12, 13, 14};
    logic [15:0] code [9] = '{`CODE_CHART_TABLE, `CODE_CHART_STEP, `CODE_HALT_INSTR, `CODE_JUMP,
                              `CODE_STRING, `CODE_DIV_ZERO, `CODE_OVERFLOW, `CODE_FLOAT, `CODE_INDEX};
    logic [4:0]  flg [9] = '{5'h02, 5'h02, 5'h00, 5'h00, 5'h04, 5'h08, 5'h08, 5'h08, 5'h10};
    diag <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      wr(`ADDR_CAUSE_CMD, 32'h8);
      rdm("run", `ADDR_STATUS, 32'hf000, 32'h2000);
      pulse(idx[k]);
      rdm("fault word", `ADDR_FAULT_TYPE, 32'hffffffff, {16'h0, code[k]});
      rdm("halt flags", `ADDR_STATUS, 32'hf01f, 32'h4000 | flg[k]);
      wr(`ADDR_STATUS, 32'h0);
      wr(`ADDR_CAUSE_CMD, 32'h10);
    end
    diag <= 1'b0;
    rdm("fault kept", `ADDR_FAULT_TYPE, 32'hffff, `CODE_INDEX);
    $display("test codes done");
  endtask

  task automatic t_wdog();
    wr(`ADDR_IRQ_STATUS, 32'hf);
    wr(`ADDR_EXEC_LIMIT, 32'd40);
    wr(`ADDR_CAUSE_CMD, 32'h8);
    repeat (8) pulse(0);
    rdm("run kept", `ADDR_STATUS, 32'hf001, 32'h2000);
    repeat (60) @(posedge clk_sys_i);
    rdm("overrun", `ADDR_STATUS, 32'hf001, 32'h4001);
    rdm("overrun code", `ADDR_FAULT_TYPE, 32'hffff, `CODE_WATCHDOG);
    rdm("irq status", `ADDR_IRQ_STATUS, 32'h8, 32'h8);
    @(negedge clk_sys_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wr(`ADDR_IRQ_MASK, 32'h8);
    @(negedge clk_sys_i);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    wr(`ADDR_IRQ_STATUS, 32'h8);
    @(negedge clk_sys_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wr(`ADDR_EXEC_LIMIT, `EXEC_LIMIT_RST);
    wr(`ADDR_STATUS, 32'h0);
    wr(`ADDR_CAUSE_CMD, 32'h10);
    $display("test watchdog done");
  endtask

  task automatic t_sys();
    pulse(16);
    chk("error", 32'h1, {31'h0, app_error_o});
    chk("diag link", 32'h0, {31'h0, diag_o});
    rdm("sys hidden", `ADDR_SYS_FAULT, 32'hff, 32'h0);
    wr(`ADDR_CAUSE_CMD, 32'h8);
    chk("error kept", 32'h1, {31'h0, app_error_o});
    pulse(5);
    rdm("forced stop", `ADDR_STATUS, 32'hf020, 32'h1020);
    rdm("cold clears fault", `ADDR_FAULT_TYPE, 32'hffff, 32'h0);
    rdm("sys wiring", `ADDR_SYS_FAULT, 32'hff, `SYS_CODE_WIRING);
    pulse(15);
    rdm("sys still hidden", `ADDR_SYS_FAULT, 32'hff, 32'h0);
    pulse(4);
    rdm("sys wdog", `ADDR_SYS_FAULT, 32'hff, `SYS_CODE_WDOG);
    wr(`ADDR_CAUSE_CMD, 32'h8);
    pulse(0);
    rdm("cold cleared", `ADDR_STATUS, 32'h20, 32'h0);
    pulse(2);
    rdm("cold power", `ADDR_STATUS, 32'h20, 32'h20);
    rdm("restart bit", `ADDR_RESTART, 32'h1, 32'h0);
    wr(`ADDR_CAUSE_CMD, 32'h8);
    pulse(0);
    wr(`ADDR_CAUSE_CMD, 32'h2);
    rdm("cold request", `ADDR_STATUS, 32'h20, 32'h20);
    $display("test system fault done");
  endtask

  task automatic t_warm();
    for (int k = 0; k < 2; k++) begin
      if (k == 0) wr(`ADDR_CAUSE_CMD, 32'h4);
      else pulse(3);
      rdm("warm set", `ADDR_STATUS, 32'h40, 32'h40);
      wr(`ADDR_CAUSE_CMD, 32'h8);
      pulse(0);
      rdm("warm in scan", `ADDR_STATUS, 32'h40, 32'h40);
      pulse(1);
      rdm("warm cleared", `ADDR_STATUS, 32'h40, 32'h0);
    end
    $display("test warm done");
  endtask

  task automatic t_io_fb();
    wr(`ADDR_CTRL, 32'h1);
    @(negedge clk_sys_i);
    chk("fallback on", 32'h1, {31'h0, fb_o});
    rdm("ctrl", `ADDR_CTRL, 32'hffffffff, 32'h1);
    wr(`ADDR_CTRL, 32'h0);
    @(negedge clk_sys_i);
    chk("fallback off", 32'h0, {31'h0, fb_o});
    wr(`ADDR_IRQ_STATUS, 32'hf);
    wr(`ADDR_IRQ_MASK, 32'h4);
    rdm("mask", `ADDR_IRQ_MASK, 32'hffffffff, 32'h4);
    rack <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rdm("io fault", `ADDR_STATUS, 32'h80, 32'h0);
    chk("io irq", 32'h1, {31'h0, irq_o});
    rack <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rdm("io ok", `ADDR_STATUS, 32'h80, 32'h80);
    wr(`ADDR_IRQ_STATUS, 32'h4);
    @(negedge clk_sys_i);
    chk("io irq clear", 32'h0, {31'h0, irq_o});
    $display("test io and fallback done");
  endtask

  // Reads take three cycles each, so 100 reads span 300 cycles.
  task automatic t_tbase();
    int         per [4] = '{5, 7, 11, 13};
    int         cnt [4] = '{0, 0, 0, 0};
    logic [3:0] prev;
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    prev = rd[11:8];
    repeat (100) begin
      xfer(1'b0, `ADDR_STATUS, 32'h0);
      for (int b = 0; b < 4; b++) if (rd[8 + b] !== prev[b]) cnt[b]++;
      prev = rd[11:8];
    end
    for (int b = 0; b < 4; b++) chk("time base", 32'h1, {31'h0, cnt[b] - 300 / per[b] inside {0, 1}});
    $display("test time bases done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_codes();
    t_wdog();
    t_sys();
    t_warm();
    t_io_fb();
    t_tbase();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    print_verdict();
  end
endmodule // controller_fault_status_unit_test
